// *** bench/pcicfg_rom_model.sv ***
`timescale 1ns/1ps
module pcicfg_rom_model (
  input wire logic rom_select, // Chip select
  input wire logic rom_serial_clock, // Serial clock
  input wire logic rom_serial_out, // Command bits into memory
  output logic rom_serial_in // Data out of memory
);
  logic [15:0] words [4] = '{16'h1af0, 16'h2be1, 16'h3cd2, 16'h4dc3};
  logic [8:0] cmd = 9'h000;
  int n = 0;
  initial rom_serial_in = 1'h0;
  // No pull on this line, so a released line must not look valid
  always @(negedge rom_select) rom_serial_in = ~rom_serial_in;
  always @(posedge rom_select) n = 0;
  always @(posedge rom_serial_clock) begin
    if (rom_select) begin
      n++;
      if (n <= 9) cmd = {cmd[7:0], rom_serial_out};
      // Data leaves MSB first after the ninth command bit
      if (n >= 9 && n < 25) rom_serial_in <= words[cmd[1:0]][24 - n];
    end
  end
endmodule : pcicfg_rom_model

// *** bench/tb_pcicfg_space.sv ***
`timescale 1ns/1ps
module tb_pcicfg_space;
  import pcicfg_pkg::*;
  localparam int DIV = 4;
  typedef struct packed {logic we; logic [5:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;}
    pcicfg_row_t;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic cfg_req = 1'h0, cfg_we = 1'h0, rom_fitted = 1'h0, pend = 1'h0;
  logic [5:0] cfg_addr = 6'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, exp_q = 32'h0, cfg_rdata;
  logic perr_e = 1'h0, serr_e = 1'h0, tab_e = 1'h0, clk_en = 1'h1;
  logic cfg_ack, cfg_busy, serr_drv_en, perr_resp_en, mem_space_en, rom_so, rom_si, rom_cs, rom_ck;
  logic [21:0] mem_window_base;
  int errors = 0, check_count = 0, cyc = 0, last_rise = 0, rise_gap = 0;
  pcicfg_row_t rows [20] = '{
    '{1'h0, 6'h00, 4'hf, 32'h0, 32'h12344321}, '{1'h0, 6'h01, 4'hf, 32'h0, 32'h00800000},
    '{1'h0, 6'h02, 4'hf, 32'h0, 32'h07000207}, '{1'h0, 6'h03, 4'hf, 32'h0, 32'h00000000},
    '{1'h1, 6'h01, 4'hf, 32'hffffffff, 32'h0}, '{1'h0, 6'h01, 4'hf, 32'h0, 32'h00800142},
    '{1'h1, 6'h04, 4'hf, 32'hffffffff, 32'h0}, '{1'h0, 6'h04, 4'hf, 32'h0, 32'hfffffc00},
    '{1'h1, 6'h04, 4'h8, 32'h00000000, 32'h0}, '{1'h0, 6'h04, 4'hf, 32'h0, 32'h00fffc00},
    '{1'h0, 6'h04, 4'h3, 32'h0, 32'h0000fc00}, '{1'h1, 6'h05, 4'hf, 32'hffffffff, 32'h0},
    '{1'h0, 6'h05, 4'hf, 32'h0, 32'h00000000}, '{1'h1, 6'h00, 4'hf, 32'hffffffff, 32'h0},
    '{1'h0, 6'h00, 4'hf, 32'h0, 32'h12344321}, '{1'h1, 6'h02, 4'hf, 32'hffffffff, 32'h0},
    '{1'h0, 6'h02, 4'hf, 32'h0, 32'h07000207}, '{1'h0, 6'h0b, 4'hf, 32'h0, 32'h00000000},
    '{1'h1, 6'h01, 4'hf, 32'h00000002, 32'h0}, '{1'h0, 6'h01, 4'hf, 32'h0, 32'h00800002}};

  pcicfg_space #(.DEV_ID_DEFAULT(16'h1234), .VEN_ID_DEFAULT(16'h4321), .REVISION(8'h07),
    .CLK_DIV(DIV)) pcicfg_space_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_busy(cfg_busy), .cfg_rdata(cfg_rdata),
    .parity_err_evt(perr_e), .sys_err_evt(serr_e), .target_abort_evt(tab_e),
    .serr_drv_en(serr_drv_en), .perr_resp_en(perr_resp_en), .mem_space_en(mem_space_en),
    .mem_window_base(mem_window_base), .rom_serial_out(rom_so), .rom_serial_in(rom_si),
    .rom_select(rom_cs), .rom_serial_clock(rom_ck), .rom_fitted(rom_fitted));
  pcicfg_rom_model pcicfg_rom_model_inst (.rom_select(rom_cs), .rom_serial_clock(rom_ck),
    .rom_serial_out(rom_so), .rom_serial_in(rom_si));

  always #2 clk = ~clk;
  always @(posedge clk) cyc++;
  always @(posedge rom_ck) begin
    rise_gap = cyc - last_rise;
    last_rise = cyc;
  end

  task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk32
  task automatic chk1(input string what, input logic e, input logic g);
    chk32(what, {31'h0, e}, {31'h0, g});
  endtask : chk1
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // One data phase; req stays high so calls in a row form a burst
  task automatic phase(input pcicfg_row_t r);
    @(negedge clk);
    if (pend) chk32("cfg_rdata", exp_q, cfg_rdata);
    cfg_req = 1'h1;
    cfg_we = r.we;
    cfg_addr = r.a;
    cfg_be = r.be;
    cfg_wdata = r.d;
    #1;
    chk1("cfg_ack", 1'h1, cfg_ack);
    pend = ~r.we;
    exp_q = r.e;
  endtask : phase
  task automatic idle();
    @(negedge clk);
    if (pend) chk32("cfg_rdata", exp_q, cfg_rdata);
    pend = 1'h0;
    cfg_req = 1'h0;
  endtask : idle
  task automatic do_reset(input logic fitted);
    @(negedge clk);
    reset_n = 1'h0;
    rom_fitted = fitted;
    repeat (2) @(negedge clk);
    reset_n = 1'h1;
    cfg_req = 1'h1;
    cfg_we = 1'h0;
    #1;
    chk1("cfg_ack while loading", 1'h0, cfg_ack);
    for (int n = 0; n < 3000 && cfg_busy !== 1'h0; n++) @(negedge clk);
    cfg_req = 1'h0;
    chk1("cfg_busy", 1'h0, cfg_busy);
  endtask : do_reset

  initial begin
    #40000;
    errors++;
    final_report();
  end
  initial begin
    do_reset(1'h0);
    foreach (rows[i]) phase(rows[i]);
    idle();
    chk1("mem_space_en", 1'h1, mem_space_en);
    chk32("mem_window_base", 32'h00003fff, {10'h0, mem_window_base});
    $display("test register map done");
    clk_en = 1'h0;
    phase('{1'h1, 6'h01, 4'hf, 32'h00000000, 32'h0});
    idle();
    clk_en = 1'h1;
    chk1("mem_space_en frozen", 1'h1, mem_space_en);
    phase('{1'h1, 6'h01, 4'hf, 32'h00000142, 32'h0});
    idle();
    chk1("serr_drv_en", 1'h1, serr_drv_en);
    chk1("perr_resp_en", 1'h1, perr_resp_en);
    @(negedge clk);
    {perr_e, serr_e, tab_e} = 3'h7;
    @(negedge clk);
    {perr_e, serr_e, tab_e} = 3'h0;
    phase('{1'h0, 6'h01, 4'hf, 32'h0, 32'hc8800142});
    phase('{1'h1, 6'h01, 4'h8, 32'hc8000000, 32'h0});
    phase('{1'h0, 6'h01, 4'hf, 32'h0, 32'h08800142});
    idle();
    $display("test status events done");
    do_reset(1'h1);
    chk1("serr_drv_en", 1'h0, serr_drv_en);
    chk1("perr_resp_en", 1'h0, perr_resp_en);
    chk1("mem_space_en", 1'h0, mem_space_en);
    chk32("mem_window_base", 32'h0, {10'h0, mem_window_base});
    chk32("rom clock period", 2 * DIV, rise_gap);
    phase('{1'h0, 6'h00, 4'hf, 32'h0, 32'h2be11af0});
    phase('{1'h0, 6'h0b, 4'hf, 32'h0, 32'h4dc33cd2});
    phase('{1'h0, 6'h01, 4'hf, 32'h0, 32'h00800000});
    idle();
    $display("test serial rom load done");
    final_report();
  end
endmodule : tb_pcicfg_space

// *** logic/pcicfg_pkg.sv ***
package pcicfg_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_STATCMD = 8'h04;
  localparam logic [7:0] OFS_CLASSREV = 8'h08;
  localparam logic [7:0] OFS_HDRMISC = 8'h0c;
  localparam logic [7:0] OFS_WINBASE = 8'h10;
  localparam logic [7:0] OFS_UNUSEDBASE = 8'h14;
  localparam logic [7:0] OFS_SUBSYS = 8'h2c;
  localparam logic [7:0] OFS_INTLINE = 8'h3c;
  // Field positions
  localparam int POS_PERR = 31;
  localparam int POS_SERRDET = 30;
  localparam int POS_TABORT = 27;
  localparam int POS_FASTB2B = 23;
  localparam int POS_SERREN = 8;
  localparam int POS_PERREN = 6;
  localparam int POS_MEMEN = 1;
  localparam int WIN_LSB = 10;
  // Reset and fixed values
  localparam logic [23:0] CLASS_CODE = 24'h070002;
  localparam logic [7:0] HDR_MISC_RST = 8'h00;
  localparam logic [7:0] INT_PIN_VAL = 8'h01;
  localparam logic [15:0] SUBSYS_RST = 16'h0000;
  // Loader timing
  localparam int ROM_CLK_DIV = 256;
  localparam int ROM_WORD_BITS = 16;
  localparam int ROM_ADDR_BITS = 6;
  localparam int ROM_WORDS = 4;
  localparam logic [2:0] ROM_READ_OP = 3'b110;
endpackage : pcicfg_pkg

// *** logic/pcicfg_space.sv ***
`timescale 1ns/1ps
module pcicfg_space import pcicfg_pkg::*; #(
  parameter logic [15:0] DEV_ID_DEFAULT = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] VEN_ID_DEFAULT = 16'ha5a5, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h10, // Arbitrary value
  parameter int CLK_DIV = ROM_CLK_DIV
) (
  input wire logic clk, // Bus clock
  input wire logic reset_n, // System reset
  input wire logic clk_en, // Freezes all state when low
  input wire logic cfg_req, // Config data phase valid
  input wire logic cfg_we, // Write phase
  input wire logic [5:0] cfg_addr, // Dword index
  input wire logic [3:0] cfg_be, // Byte enables, active high
  input wire logic [31:0] cfg_wdata, // Write data
  output logic cfg_ack, // Phase accepted
  output logic cfg_busy, // Loader running, retry
  output logic [31:0] cfg_rdata, // Read data
  input wire logic parity_err_evt, // Parity error seen
  input wire logic sys_err_evt, // System error raised
  input wire logic target_abort_evt, // Transaction ended with abort
  output logic serr_drv_en, // System error driver enable
  output logic perr_resp_en, // Parity response enable
  output logic mem_space_en, // Memory space response enable
  output logic [21:0] mem_window_base, // Base of 1K window
  output logic rom_serial_out, // Data to ROM
  input wire logic rom_serial_in, // Data from ROM
  output logic rom_select, // ROM chip select
  output logic rom_serial_clock, // ROM clock
  input wire logic rom_fitted // ROM present strap
);
  typedef enum logic [2:0] {
    PC_IDLE = 3'b000, PC_SEL = 3'b001, PC_SHIFT = 3'b011, PC_DONE = 3'b010
  } pcicfg_state_t;
  localparam int DIV_W = $clog2(CLK_DIV);
  localparam int CMD_BITS = 3 + ROM_ADDR_BITS;
  localparam int FRAME = CMD_BITS + ROM_WORD_BITS;

  pcicfg_state_t state_q;
  logic [DIV_W-1:0] div_q;
  logic [5:0] bit_q;
  logic [1:0] word_q;
  logic [15:0] shift_q;
  logic [15:0] dev_id_q, ven_id_q, sub_id_q, sub_ven_q;
  logic sin_m_q, sin_q, fit_m_q, fit_q;
  logic perr_q, serr_q, tabort_q, serren_q, perren_q, memen_q;
  logic [21:0] base_q;
  logic [7:0] int_line_q;
  logic [31:0] rdata_d;
  logic tick, wr, busy;
  logic [CMD_BITS-1:0] cmd;
  logic [31:0] mask;

  // Two-flop synchronisers for pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sin_m_q <= 1'b0;
      sin_q <= 1'b0;
      fit_m_q <= 1'b0;
      fit_q <= 1'b0;
    end else if (clk_en) begin
      sin_m_q <= rom_serial_in;
      sin_q <= sin_m_q;
      fit_m_q <= rom_fitted;
      fit_q <= fit_m_q;
    end
  end

  assign tick = (div_q == DIV_W'(CLK_DIV - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div_q <= '0;
    else if (clk_en) div_q <= tick ? '0 : div_q + 1'b1;
  end

  assign busy = (state_q != PC_DONE);
  assign cmd = {ROM_READ_OP, 4'h0, word_q};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PC_IDLE;
      bit_q <= '0;
      word_q <= '0;
      shift_q <= '0;
      rom_select <= 1'b0;
      rom_serial_clock <= 1'b0;
      rom_serial_out <= 1'b0;
    end else if (clk_en && tick) begin
      case (state_q)
        PC_IDLE: begin
          state_q <= fit_q ? PC_SEL : PC_DONE;
        end
        PC_SEL: begin
          rom_select <= 1'b1;
          bit_q <= '0;
          rom_serial_out <= cmd[CMD_BITS-1];
          state_q <= PC_SHIFT;
        end
        PC_SHIFT: begin
          rom_serial_clock <= ~rom_serial_clock;
          if (rom_serial_clock) begin
            bit_q <= bit_q + 1'b1;
            if (bit_q + 1 < CMD_BITS)
              rom_serial_out <= cmd[CMD_BITS - 2 - int'(bit_q)];
            else
              rom_serial_out <= 1'b0;
            if (bit_q == 6'(FRAME - 1)) begin
              rom_select <= 1'b0;
              word_q <= word_q + 1'b1;
              state_q <= (word_q == 2'(ROM_WORDS - 1)) ? PC_DONE : PC_SEL;
            end
          end else if (int'(bit_q) >= CMD_BITS) begin
            shift_q <= {shift_q[14:0], sin_q};
          end
        end
        default: state_q <= PC_DONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_id_q <= DEV_ID_DEFAULT;
      ven_id_q <= VEN_ID_DEFAULT;
      sub_id_q <= SUBSYS_RST;
      sub_ven_q <= SUBSYS_RST;
    end else if (clk_en && tick && state_q == PC_SHIFT && rom_serial_clock
                 && bit_q == 6'(FRAME - 1)) begin
      case (word_q)
        2'd0: ven_id_q <= shift_q;
        2'd1: dev_id_q <= shift_q;
        2'd2: sub_ven_q <= shift_q;
        default: sub_id_q <= shift_q;
      endcase
    end
  end

  assign mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign cfg_busy = busy;
  assign cfg_ack = cfg_req & ~busy;
  assign wr = clk_en & cfg_ack & cfg_we;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      perr_q <= 1'b0;
      serr_q <= 1'b0;
      tabort_q <= 1'b0;
    end else if (clk_en) begin
      perr_q <= parity_err_evt | (perr_q &
        ~(wr && cfg_addr == 6'(OFS_STATCMD >> 2) && cfg_be[3] && cfg_wdata[POS_PERR]));
      serr_q <= sys_err_evt | (serr_q &
        ~(wr && cfg_addr == 6'(OFS_STATCMD >> 2) && cfg_be[3] && cfg_wdata[POS_SERRDET]));
      tabort_q <= tabort_q | target_abort_evt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serren_q <= 1'b0;
      perren_q <= 1'b0;
      memen_q <= 1'b0;
      base_q <= '0;
      int_line_q <= '0;
    end else if (wr) begin
      if (cfg_addr == 6'(OFS_STATCMD >> 2)) begin
        if (cfg_be[1]) serren_q <= cfg_wdata[POS_SERREN];
        if (cfg_be[0]) begin
          perren_q <= cfg_wdata[POS_PERREN];
          memen_q <= cfg_wdata[POS_MEMEN];
        end
      end else if (cfg_addr == 6'(OFS_WINBASE >> 2)) begin
        base_q <= (base_q & ~mask[31:WIN_LSB]) | (cfg_wdata[31:WIN_LSB] & mask[31:WIN_LSB]);
      end else if (cfg_addr == 6'(OFS_INTLINE >> 2)) begin
        if (cfg_be[0]) int_line_q <= cfg_wdata[7:0];
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (cfg_addr == 6'(OFS_IDENTITY >> 2)) begin
      rdata_d = {dev_id_q, ven_id_q};
    end else if (cfg_addr == 6'(OFS_STATCMD >> 2)) begin
      rdata_d[POS_PERR] = perr_q;
      rdata_d[POS_SERRDET] = serr_q;
      rdata_d[POS_TABORT] = tabort_q;
      rdata_d[POS_FASTB2B] = 1'b1;
      rdata_d[POS_SERREN] = serren_q;
      rdata_d[POS_PERREN] = perren_q;
      rdata_d[POS_MEMEN] = memen_q;
    end else if (cfg_addr == 6'(OFS_CLASSREV >> 2)) begin
      rdata_d = {CLASS_CODE, REVISION};
    end else if (cfg_addr == 6'(OFS_HDRMISC >> 2)) begin
      rdata_d = {4{HDR_MISC_RST}};
    end else if (cfg_addr == 6'(OFS_WINBASE >> 2)) begin
      rdata_d = {base_q, 10'h000};
    end else if (cfg_addr == 6'(OFS_SUBSYS >> 2)) begin
      rdata_d = {sub_id_q, sub_ven_q};
    end else if (cfg_addr == 6'(OFS_INTLINE >> 2)) begin
      rdata_d = {16'h0000, INT_PIN_VAL, int_line_q};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cfg_rdata <= '0;
    else if (clk_en && cfg_ack && !cfg_we) cfg_rdata <= rdata_d & mask;
  end

  assign serr_drv_en = serren_q;
  assign perr_resp_en = perren_q;
  assign mem_space_en = memen_q;
  assign mem_window_base = base_q;

  AST_PERR_SET: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && parity_err_evt |=> perr_q) else $error("parity status not set");
  AST_TABORT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    tabort_q |=> tabort_q) else $error("abort status cleared");
  AST_NO_ACK_BUSY: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_busy |-> !cfg_ack) else $error("answered during load");
  AST_IO_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    $past(cfg_ack && !cfg_we && cfg_addr == 6'h01) |-> cfg_rdata[0] == 1'b0)
    else $error("io enable read one");
  AST_BASE_LOW: assert property (@(posedge clk) disable iff (!reset_n)
    $past(cfg_ack && !cfg_we && cfg_addr == 6'h04) |-> cfg_rdata[9:0] == 10'h000)
    else $error("window low bits set");
  AST_BASE1_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    $past(cfg_ack && !cfg_we && cfg_addr == 6'h05) |-> cfg_rdata == 32'h0)
    else $error("second base nonzero");
  AST_FB2B: assert property (@(posedge clk) disable iff (!reset_n)
    $past(cfg_ack && !cfg_we && cfg_addr == 6'h01 && cfg_be[2] && clk_en)
    |-> cfg_rdata[26:23] == 4'h1) else $error("status capability wrong");
  AST_MEMEN_WR: assert property (@(posedge clk) disable iff (!reset_n)
    wr && cfg_addr == 6'h01 && cfg_be[0] |=> mem_space_en == $past(cfg_wdata[1]))
    else $error("memory enable not written");
  AST_ROMCLK_DIV: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(tick) |-> $stable(rom_serial_clock)) else $error("rom clock too fast");

  AST_SERR_SET: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && sys_err_evt |=> serr_q) else $error("system error status not set");
  AST_PERR_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    wr && !parity_err_evt && cfg_addr == 6'(OFS_STATCMD >> 2) && cfg_be[3]
    && cfg_wdata[POS_PERR] |=> !perr_q) else $error("parity status not cleared");
  AST_SERR_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    wr && !sys_err_evt && cfg_addr == 6'(OFS_STATCMD >> 2) && cfg_be[3]
    && cfg_wdata[POS_SERRDET] |=> !serr_q) else $error("system status not cleared");
  AST_TABORT_SET: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && target_abort_evt |=> tabort_q) else $error("abort status not set");
  AST_SERREN_WR: assert property (@(posedge clk) disable iff (!reset_n)
    wr && cfg_addr == 6'(OFS_STATCMD >> 2) && cfg_be[1]
    |=> serr_drv_en == $past(cfg_wdata[POS_SERREN])) else $error("driver enable not written");
  AST_PERREN_WR: assert property (@(posedge clk) disable iff (!reset_n)
    wr && cfg_addr == 6'(OFS_STATCMD >> 2) && cfg_be[0]
    |=> perr_resp_en == $past(cfg_wdata[POS_PERREN])) else $error("parity enable not written");
  AST_BASE_WR: assert property (@(posedge clk) disable iff (!reset_n)
    wr && cfg_addr == 6'(OFS_WINBASE >> 2) && cfg_be[3]
    |=> mem_window_base[21:14] == $past(cfg_wdata[31:24])) else $error("window base not written");
  AST_CLASS: assert property (@(posedge clk) disable iff (!reset_n)
    $past(clk_en && cfg_ack && !cfg_we && cfg_addr == 6'(OFS_CLASSREV >> 2) && cfg_be == 4'hf)
    |-> cfg_rdata == {CLASS_CODE, REVISION}) else $error("class code wrong");
  AST_HDR_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    $past(clk_en && cfg_ack && !cfg_we && cfg_addr == 6'(OFS_HDRMISC >> 2))
    |-> cfg_rdata == 32'h00000000) else $error("header word nonzero");
  AST_CMD_RSVD: assert property (@(posedge clk) disable iff (!reset_n)
    $past(clk_en && cfg_ack && !cfg_we && cfg_addr == 6'(OFS_STATCMD >> 2))
    |-> (cfg_rdata & 32'h307ffebd) == 32'h00000000) else $error("reserved bit set");
  AST_MASK_LANE: assert property (@(posedge clk) disable iff (!reset_n)
    $past(clk_en && cfg_ack && !cfg_we && !cfg_be[0])
    |-> cfg_rdata[7:0] == 8'h00) else $error("disabled lane not zero");
  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !(clk_en && cfg_ack && !cfg_we) |=> $stable(cfg_rdata)) else $error("read data moved");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(state_q) && $stable(div_q) && $stable(base_q))
    else $error("state moved while frozen");
  AST_NO_FIT: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && tick && state_q == PC_IDLE && !fit_q |=> state_q == PC_DONE)
    else $error("loader ran without rom");
  AST_IDS_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !busy |=> $stable(dev_id_q) && $stable(ven_id_q)) else $error("ids changed after load");
  AST_ROM_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    !busy |-> !rom_select && !rom_serial_clock) else $error("rom link active after load");
  AST_SEL_CLK: assert property (@(posedge clk) disable iff (!reset_n)
    rom_serial_clock |-> rom_select) else $error("rom clocked while deselected");
endmodule : pcicfg_space
